//--- bench/pipe_issue_model.sv
// Issuing pipeline model: one operation per call, driven at the falling edge.
// Assumes the bench calls issue back to back and idle when it stops issuing.
`timescale 1ns/10ps
`default_nettype none
module pipe_issue_model (
  input  wire logic            ref_clk,
  output logic                 op_valid,
  output var simd_dp_pkg::op_type op,
  output logic [1:0]           elem_size,
  output logic                 is_signed,
  output logic                 shift_by_vector,
  output logic [6:0]           imm_shift,
  output logic [63:0]          src_a,
  output logic [63:0]          src_b,
  output logic [63:0]          src_d
);
  import simd_dp_pkg::*;
  initial begin
    op_valid = 0;
    op = register_copy_op;
    elem_size = 0;
    is_signed = 0;
    shift_by_vector = 0;
    imm_shift = 0;
    src_a = 0;
    src_b = 0;
    src_d = 0;
  end
  task automatic issue(input op_type o, input logic [1:0] es,
      input logic sg, vec, input logic [6:0] n, input logic [63:0] a, b, d);
    @(negedge ref_clk);
    op_valid = 1;
    op = o;
    elem_size = es;
    is_signed = sg;
    shift_by_vector = vec;
    imm_shift = n;
    src_a = a;
    src_b = b;
    src_d = d;
  endtask
  // Released operands are scrambled so stale values cannot pass
  task automatic idle();
    @(negedge ref_clk);
    op_valid = 0;
    src_a = ~src_a;
    src_b = ~src_b;
    src_d = ~src_d;
    imm_shift = ~imm_shift;
  endtask
endmodule // pipe_issue_model
`default_nettype wire

//--- bench/simd_dp_assertions.sv
// Concurrent checks on the ports of the SIMD lane datapath.
// Assumes one clock domain; bound to the datapath top module.
`timescale 1ns/10ps
`default_nettype none
module simd_dp_assertions (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                op_valid,
  input wire simd_dp_pkg::op_type op,
  input wire logic [1:0]          elem_size,
  input wire logic                is_signed,
  input wire logic                shift_by_vector,
  input wire logic [6:0]          imm_shift,
  input wire logic [63:0]         src_a,
  input wire logic [63:0]         src_b,
  input wire logic [63:0]         src_d,
  input wire logic                res_valid,
  input wire logic [63:0]         result,
  input wire logic                fp_inexact,
  input wire logic                fp_underflow,
  input wire logic                saturated,
  input wire logic                op_illegal
);
  import simd_dp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_answer_next: assert property (op_valid |=> res_valid)
    else $error("no answer one cycle after a request");
  a_no_stray: assert property (
    !op_valid |=> !res_valid && $stable(result))
    else $error("answer or result change without a request");
  a_no_underflow: assert property (!fp_underflow)
    else $error("underflow flag raised");
  a_unnarrowed_refused: assert property (
    op_valid && op == sat_right_unnarrowed_op
    |=> op_illegal && result == 64'h0)
    else $error("unnarrowed saturating right shift accepted");
  a_refused_quiet: assert property (
    op_illegal |-> result == 64'h0 && !saturated && !fp_inexact)
    else $error("refused operation left a value or flag");
  a_right_fill: assert property (
    op_valid && op == shift_right_op && elem_size == ES_BYTE &&
    imm_shift inside {[1:7]} |=> result[7:0] == ($past(is_signed) ?
    8'($signed($past(src_a[7:0])) >>> $past(imm_shift)) :
    $past(src_a[7:0]) >> $past(imm_shift)))
    else $error("byte right shift fill wrong");
  a_left_insert: assert property (
    op_valid && op == left_insert_op && elem_size == ES_BYTE &&
    imm_shift < 7'h8 |=> result[7:0] ==
    (8'($past(src_a[7:0]) << $past(imm_shift)) |
    ($past(src_d[7:0]) & 8'((9'h001 << $past(imm_shift)) - 9'h001))))
    else $error("left insert lost destination bits");
  a_copy_through: assert property (
    op_valid && op == register_copy_op |=> result == $past(src_a) &&
    !fp_inexact)
    else $error("copy altered its operand");
  a_swap_through: assert property (
    op_valid && op == swap_op |=> result == $past(src_b))
    else $error("swap did not return the second operand");
  a_denorm_zero: assert property (
    op_valid && op == fp_half_op && elem_size == ES_WORD &&
    src_a[30:23] == 8'h0 && src_a[22:0] != 23'h0
    |=> result[31:0] == {$past(src_a[31]), 31'h0} && fp_inexact)
    else $error("denormal input not taken as signed zero");
  c_fp_half: cover property (op_valid && op == fp_half_op);
  c_refused: cover property (op_illegal);
  c_clamped: cover property (saturated);
endmodule // simd_dp_assertions
bind simd_shift_and_ftz_datapath simd_dp_assertions simd_dp_assertions_inst (
  .ref_clk, .rst, .op_valid, .op, .elem_size, .is_signed, .shift_by_vector,
  .imm_shift, .src_a, .src_b, .src_d, .res_valid, .result, .fp_inexact,
  .fp_underflow, .saturated, .op_illegal);
`default_nettype wire

//--- bench/test_simd_shift_and_ftz_datapath.sv
// Self-checking bench for the SIMD shift and flush-to-zero datapath.
// Assumes the issue model drives every datapath input except the clock and reset.
`timescale 1ns/10ps
`default_nettype none
module test_simd_shift_and_ftz_datapath;
  import simd_dp_pkg::*;
  logic ref_clk, rst, op_valid, is_signed, shift_by_vector, res_valid;
  logic fp_inexact, fp_underflow, saturated, op_illegal, sg;
  op_type op;
  logic [1:0] elem_size;
  logic [6:0] imm_shift;
  logic [63:0] src_a, src_b, src_d, result, a, b, r;
  logic [66:0] exp_q[$], e;
  int num_errors, comparisons, n, c;
  pipe_issue_model pipe_issue_model_inst (.ref_clk(ref_clk),
    .op_valid(op_valid), .op(op), .elem_size(elem_size),
    .is_signed(is_signed), .shift_by_vector(shift_by_vector),
    .imm_shift(imm_shift), .src_a(src_a), .src_b(src_b), .src_d(src_d));
  simd_shift_and_ftz_datapath simd_shift_and_ftz_datapath_inst (
    .ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op(op),
    .elem_size(elem_size), .is_signed(is_signed),
    .shift_by_vector(shift_by_vector), .imm_shift(imm_shift),
    .src_a(src_a), .src_b(src_b), .src_d(src_d), .res_valid(res_valid),
    .result(result), .fp_inexact(fp_inexact), .fp_underflow(fp_underflow),
    .saturated(saturated), .op_illegal(op_illegal));
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [66:0] s, x);
    comparisons++;
    if (s !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  function automatic logic [7:0] sh8(logic [7:0] x, int k, logic s);
    if (k >= 0) return x << k;
    return s ? 8'($signed(x) >>> (-k)) : x >> (-k);
  endfunction
  // Notes the expected {illegal, saturated, inexact, result}, then issues
  task automatic go(input op_type o, input logic [1:0] es, input logic s,
      v, input logic [6:0] k, input logic [63:0] x, y, d, rr,
      input logic [2:0] f);
    exp_q.push_back({f, rr});
    pipe_issue_model_inst.issue(o, es, s, v, k, x, y, d);
  endtask
  always @(posedge ref_clk) begin
    #1;
    if (res_valid === 1'b1) begin
      check("underflow", 67'(fp_underflow), 67'h0);
      if (exp_q.size() == 0) check("stray answer", 67'h1, 67'h0);
      else begin
        e = exp_q.pop_front();
        check("answer", {op_illegal, saturated, fp_inexact, result}, e);
      end
    end
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(63));
    repeat (3) @(negedge ref_clk);
    rst = 0;
    for (int k = 0; k < 8; k++) begin
      a = {$urandom, $urandom};
      n = 1 + $urandom % 7;
      sg = k[0];
      for (int i = 0; i < 8; i++) r[i*8 +: 8] = sh8(a[i*8 +: 8], -n, sg);
      go(shift_right_op, ES_BYTE, sg, 0, 7'(n), a, 0, 0, r, 0);
    end
    for (int i = 0; i < 8; i++) begin
      c = i - 4;
      b[i*8 +: 8] = 8'(c);
      r[i*8 +: 8] = sh8(8'h96, c, 1);
    end
    go(shift_left_op, ES_BYTE, 1, 1, 0, {8{8'h96}}, b, 0, r, 0);
    $display("shift tests done");
    go(left_insert_op, ES_BYTE, 0, 0, 3, {8{8'hF0}}, 0, {8{8'h5A}},
       {8{8'h82}}, 0);
    go(right_insert_op, ES_BYTE, 0, 0, 3, {8{8'hF0}}, 0, {8{8'h5A}},
       {8{8'h5E}}, 0);
    go(right_accumulate_op, ES_BYTE, 0, 0, 3, {8{8'hF4}}, 0, {8{8'h5A}},
       {8{8'h78}}, 0);
    go(round_right_accumulate_op, ES_BYTE, 0, 0, 3, {8{8'hF4}}, 0,
       {8{8'h5A}}, {8{8'h79}}, 0);
    go(round_shift_right_op, ES_BYTE, 0, 0, 2, {8{8'h06}}, 0, 0,
       {8{8'h02}}, 0);
    go(usat_shift_left_op, ES_BYTE, 1, 0, 2, 64'h0110_7F80, 0, 0,
       64'h0440_FF00, 3'b010);
    go(sat_shift_left_op, ES_BYTE, 1, 0, 2, 64'h0110_7F80, 0, 0,
       64'h0440_7F80, 3'b010);
    go(shift_right_narrow_op, ES_HALF, 0, 0, 4, 64'h1234_5678_9ABC_DEF0,
       64'h0FED_CBA9_8765_4321, 0, 64'hFEBA_7632_2367_ABEF, 0);
    go(shift_left_long_op, ES_BYTE, 1, 0, 1, 64'h017F_80FF, 0, 0,
       64'h0002_00FE_FF00_FFFE, 0);
    go(sat_round_right_narrow_op, ES_HALF, 1, 0, 4, 64'hFFE8_0018_8000_7FF8,
       0, 0, 64'h0000_0000_FF02_807F, 3'b010);
    go(usat_round_right_narrow_op, ES_HALF, 1, 0, 4, 64'hFFE8_0018_8000_7FF8,
       0, 0, 64'h0000_0000_0002_00FF, 3'b010);
    go(sat_shift_right_narrow_op, ES_HALF, 0, 0, 4, 64'hFFE8_0018_8000_7FF8,
       0, 0, 64'h0000_0000_FF01_FFFF, 3'b010);
    go(usat_shift_right_narrow_op, ES_HALF, 1, 0, 4, 64'hFFE8_0018_8000_7FF8,
       0, 0, 64'h0000_0000_0001_00FF, 3'b010);
    go(round_shift_left_op, ES_WORD, 0, 1, 0, 64'h8000_0001_0000_0007,
       64'h0000_0004_0000_00FF, 0, 64'h0000_0010_0000_0004, 0);
    go(sat_round_shift_left_op, ES_DWORD, 1, 1, 0, 64'h4000_0000_0000_0000,
       64'h01, 0, 64'h7FFF_FFFF_FFFF_FFFF, 3'b010);
    $display("insert and modifier tests done");
    go(fp_half_op, ES_WORD, 0, 0, 0, 64'h4000_0000_8000_0001, 0, 0,
       64'h3F80_0000_8000_0000, 3'b001);
    go(fp_half_op, ES_WORD, 0, 0, 0, 64'h3F80_0000_0080_0000, 0, 0,
       64'h3F00_0000_0000_0000, 3'b001);
    go(fp_half_op, ES_DWORD, 0, 0, 0, 64'h8010_0000_0000_0000, 0, 0,
       64'h8000_0000_0000_0000, 3'b001);
    go(fp_half_op, ES_DWORD, 0, 0, 0, 64'h4000_0000_0000_0000, 0, 0,
       64'h3FF0_0000_0000_0000, 0);
    go(register_copy_op, ES_WORD, 0, 0, 0, 64'h0000_0001_8000_0001, 0, 0,
       64'h0000_0001_8000_0001, 0);
    go(negate_op, ES_WORD, 0, 0, 0, 64'h0000_0001_8000_0001, 0, 0,
       64'h8000_0001_0000_0001, 0);
    go(swap_op, ES_WORD, 0, 0, 0, 0, 64'h0000_0001_8000_0001, 0,
       64'h0000_0001_8000_0001, 0);
    go(fp_max_op, ES_WORD, 0, 0, 0, 64'h3F80_0000_8000_0001,
       64'h4000_0000_0000_0001, 0, 64'h4000_0000_0000_0000, 3'b001);
    go(fp_min_op, ES_WORD, 0, 0, 0, 64'h3F80_0000_8000_0001,
       64'h4000_0000_0000_0001, 0, 64'h3F80_0000_8000_0000, 3'b001);
    go(duplicate_op, ES_HALF, 0, 0, 0, 64'h1111_2222_3333_0001, 0, 0,
       {4{16'h0001}}, 0);
    go(invert_move_op, ES_WORD, 0, 0, 0, 64'h0000_0000_0000_0001, 0, 0,
       64'hFFFF_FFFF_FFFF_FFFE, 0);
    go(absolute_value_op, ES_DWORD, 0, 0, 0, 64'h8000_0000_0000_0001, 0, 0,
       64'h0000_0000_0000_0001, 0);
    $display("flush tests done");
    go(sat_right_unnarrowed_op, ES_HALF, 1, 0, 2, '1, '1, 0, 0,
       3'b100);
    go(shift_right_narrow_op, ES_BYTE, 0, 0, 1, '1, '1, 0, 0, 3'b100);
    go(poly_mul_op, ES_BYTE, 0, 0, 0, 64'h0303_0303_0303_03FF,
       {8{8'h03}}, 0, 64'h0505_0505_0505_0501, 0);
    go(poly_mul_op, ES_HALF, 0, 0, 0, 64'h8000_0003_0003_0003,
       {4{16'h0003}}, 0, 64'h8000_0005_0005_0005, 0);
    pipe_issue_model_inst.idle();
    for (int w = 0; w < 20 && exp_q.size() != 0; w++) @(posedge ref_clk);
    if (exp_q.size() != 0) check("missing answers", 67'h1, 67'h0);
    $display("refusal and polynomial tests done");
    final_report();
  end
endmodule // test_simd_shift_and_ftz_datapath
`default_nettype wire

//--- hw/simd_dp_pkg.sv
// Constants, operation codes and state types of the SIMD lane datapath.
// Assumes one clock domain and operands presented by the issuing pipeline.
package simd_dp_pkg;
  localparam int          DATA_W     = 64;
  localparam logic [1:0]  ES_BYTE    = 2'h0;
  localparam logic [1:0]  ES_HALF    = 2'h1;
  localparam logic [1:0]  ES_WORD    = 2'h2;
  localparam logic [1:0]  ES_DWORD   = 2'h3;
  localparam logic [1:0]  OW_HALF    = 2'h0;
  localparam logic [1:0]  OW_SAME    = 2'h1;
  localparam logic [1:0]  OW_DBL     = 2'h2;
  localparam logic [1:0]  SAT_NONE   = 2'h0;
  localparam logic [1:0]  SAT_TYPED  = 2'h1;
  localparam logic [1:0]  SAT_UNS    = 2'h2;
  localparam logic [1:0]  INS_NONE   = 2'h0;
  localparam logic [1:0]  INS_LEFT   = 2'h1;
  localparam logic [1:0]  INS_RIGHT  = 2'h2;
  localparam logic [63:0] SP_SIGN    = 64'h0000_0000_8000_0000;
  localparam logic [63:0] DP_SIGN    = 64'h8000_0000_0000_0000;
  localparam logic [63:0] SP_EXP_LSB = 64'h0000_0000_0080_0000;
  localparam logic [63:0] DP_EXP_LSB = 64'h0010_0000_0000_0000;
  localparam logic [63:0] SP_KEY_MSK = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] RESULT_RST = 64'h0;

  typedef enum logic [5:0] {
    register_copy_op, invert_move_op, absolute_value_op, negate_op,
    duplicate_op, swap_op,
    shift_left_op, shift_left_long_op, round_shift_left_op,
    shift_right_op, shift_right_narrow_op, round_shift_right_op,
    round_shift_right_narrow_op, left_insert_op, right_insert_op,
    right_accumulate_op, round_right_accumulate_op,
    sat_shift_left_op, sat_round_shift_left_op,
    sat_shift_right_narrow_op, sat_round_right_narrow_op,
    usat_shift_left_op, usat_shift_right_narrow_op,
    usat_round_right_narrow_op, sat_right_unnarrowed_op,
    fp_max_op, fp_min_op, fp_half_op, poly_mul_op
  } op_type;

  typedef struct packed {
    logic [1:0] ow_sel;
    logic [1:0] sat_kind;
    logic [1:0] ins;
    logic       round;
    logic       accumulate;
    logic       signed_in;
    logic       use_reg;
  } lane_ctl_type;

  typedef struct packed {
    logic        valid;
    logic [63:0] result;
    logic        inexact;
    logic        underflow;
    logic        saturated;
    logic        illegal;
  } state_type;
endpackage

//--- hw/simd_shift_and_ftz_datapath.sv
// Per-lane SIMD datapath: shifts, flush-to-zero FP, polynomial lanes.
// Assumes the pipeline holds operands stable for the cycle op_valid is high.
// Operation
// - Denormal FP inputs are used as zero; source operands stay untouched.
// - Single results below 2^-126 in magnitude become zero.
// - Double results below 2^-1022 in magnitude become zero.
// - Inexact flags on denormal input use or on a flushed result.
// - Underflow is never signalled.
// - Copy, invert, abs, negate, duplicate, swap pass denormals unflushed.
// - Shifts stay inside each element; spilled bits are dropped.
// - Shift count comes from the immediate or from a per-lane vector.
// - Vector counts are signed: positive left, negative right, zero none.
// - Signed right shifts fill with the element sign bit.
// - Unsigned right shifts fill with zeros.
// - Left insert keeps destination bits in vacated low positions.
// - Right accumulate adds the shifted source into the destination.
// - Unsigned saturation clamps to the unsigned destination range.
// - Unnarrowed saturating right shift does not exist; it is refused.
// - All listed non-saturating shift forms are provided.
// - All listed saturating and unsigned-saturating forms are provided.
// - Polynomial lanes are 8 or 16 bits, bit n is coefficient n.
// - Flush-to-zero is always in force, with no full-denormal mode.
// - A flushed value keeps its sign.
// - FP arithmetic rounds to nearest only.
// - Polynomial multiply combines partial products by exclusive OR.
`timescale 1ns/10ps
`default_nettype none

module shift_lane #(
  parameter int SW = 8
) (
  input  wire logic [SW-1:0]             src,
  input  wire logic [2*SW-1:0]           dst,
  input  wire logic signed [7:0]         cnt,
  input  wire simd_dp_pkg::lane_ctl_type ctl,
  output logic [2*SW-1:0]                res,
  output logic                           sat
);
  import simd_dp_pkg::*;
  localparam int IW = 4*SW+2;
  logic signed [IW-1:0] ext;
  logic signed [IW-1:0] v;
  logic signed [IW-1:0] rnd;
  logic signed [IW-1:0] ones;
  logic signed [IW-1:0] hi;
  logic signed [IW-1:0] lo;
  logic signed [IW-1:0] acc;
  logic signed [IW-1:0] keep;
  int ow;
  int lc;
  int rc;

  always_comb begin
    ow = (ctl.ow_sel == OW_HALF) ? SW/2 :
         (ctl.ow_sel == OW_DBL) ? 2*SW : SW;
    if (ctl.signed_in)
      ext = IW'(signed'(src));
    else
      ext = IW'(src);
    lc = 0;
    rc = 0;
    if (cnt > 0)
      lc = (int'(cnt) > 2*SW) ? 2*SW : int'(cnt);
    else if (cnt < 0)
      rc = (-int'(cnt) > SW+1) ? SW+1 : -int'(cnt);
    rnd = '0;
    if (ctl.round && rc > 0)
      rnd[rc-1] = 1'b1;
    if (rc == 0)
      v = ext <<< lc;
    else
      v = (ext + rnd) >>> rc;
    ones = '0;
    ones[ow] = 1'b1;
    ones = ones - 1;
    if (ctl.sat_kind == SAT_UNS ||
        (ctl.sat_kind == SAT_TYPED && !ctl.signed_in)) begin
      lo = '0;
      hi = ones;
    end else begin
      hi = ones >>> 1;
      lo = ~hi;
    end
    acc = v;
    sat = 1'b0;
    if (ctl.accumulate)
      acc = v + signed'(IW'(dst));
    if (ctl.sat_kind != SAT_NONE) begin
      if (v > hi) begin
        acc = hi;
        sat = 1'b1;
      end else if (v < lo) begin
        acc = lo;
        sat = 1'b1;
      end
    end
    unique case (ctl.ins)
      INS_LEFT:  keep = ones & ~(ones <<< lc);
      INS_RIGHT: keep = ones & ~(ones >>> rc);
      default:   keep = '0;
    endcase
    acc = (acc & ~keep) | (signed'(IW'(dst)) & keep);
    res = acc[2*SW-1:0] & ones[2*SW-1:0];
  end
endmodule // shift_lane

module simd_shift_and_ftz_datapath (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               op_valid,
  input  wire simd_dp_pkg::op_type op,
  input  wire logic [1:0]         elem_size,
  input  wire logic               is_signed,
  input  wire logic               shift_by_vector,
  input  wire logic [6:0]         imm_shift,
  input  wire logic [63:0]        src_a,
  input  wire logic [63:0]        src_b,
  input  wire logic [63:0]        src_d,
  output logic                    res_valid,
  output logic [63:0]             result,
  output logic                    fp_inexact,
  output logic                    fp_underflow,
  output logic                    saturated,
  output logic                    op_illegal
);
  import simd_dp_pkg::*;

  state_type            st_q;
  state_type            st_d;
  lane_ctl_type         ctl;
  logic                 right;
  logic                 shift_op;
  logic signed [7:0]    cnt_imm;
  wire [3:0][63:0]      shift_res;
  wire [3:0]            sat_es;

  function automatic logic [64:0] fp_calc(
    input logic [63:0] x,
    input logic [63:0] y,
    input logic        dbl,
    input logic        half,
    input logic        fmax
  );
    logic [63:0] sg;
    logic [63:0] fx;
    logic [63:0] fy;
    logic [63:0] kx;
    logic [63:0] ky;
    logic [63:0] r;
    logic [10:0] ex;
    logic [10:0] ey;
    logic [10:0] etop;
    logic        dx;
    logic        dy;
    logic        ix;
    sg   = dbl ? DP_SIGN : SP_SIGN;
    ex   = dbl ? x[62:52] : {3'h0, x[30:23]};
    ey   = dbl ? y[62:52] : {3'h0, y[30:23]};
    etop = dbl ? 11'h7FF : 11'h0FF;
    dx   = (ex == 11'h0) && (dbl ? |x[51:0] : |x[22:0]);
    dy   = (ey == 11'h0) && (dbl ? |y[51:0] : |y[22:0]);
    fx   = dx ? (x & sg) : x;
    fy   = dy ? (y & sg) : y;
    ix   = 1'b0;
    if (half) begin
      ix = dx;
      if (ex == 11'h0 || ex == etop)
        r = fx;
      else if (ex == 11'h1) begin
        r  = fx & sg;
        ix = 1'b1;
      end else
        r = fx - (dbl ? DP_EXP_LSB : SP_EXP_LSB);
    end else begin
      ix = dx | dy;
      kx = (fx & sg) != 64'h0 ? ~fx : (fx | sg);
      ky = (fy & sg) != 64'h0 ? ~fy : (fy | sg);
      if (!dbl) begin
        kx = kx & SP_KEY_MSK;
        ky = ky & SP_KEY_MSK;
      end
      r = ((kx > ky) == fmax) ? fx : fy;
    end
    return {ix, r};
  endfunction

  function automatic logic [15:0] clmul(
    input logic [15:0] x,
    input logic [15:0] y
  );
    logic [15:0] p;
    p = 16'h0;
    for (int j = 0; j < 16; j++)
      if (y[j])
        p = p ^ (x << j);
    return p;
  endfunction

  always_comb begin
    ctl           = '0;
    ctl.ow_sel    = OW_SAME;
    ctl.signed_in = is_signed;
    right         = 1'b0;
    shift_op      = 1'b1;
    unique case (op)
      shift_left_op: ctl.use_reg = shift_by_vector;
      shift_left_long_op: ctl.ow_sel = OW_DBL;
      round_shift_left_op: begin
        ctl.use_reg = 1'b1;
        ctl.round   = 1'b1;
      end
      shift_right_op: right = 1'b1;
      shift_right_narrow_op: begin
        right      = 1'b1;
        ctl.ow_sel = OW_HALF;
      end
      round_shift_right_op: begin
        right     = 1'b1;
        ctl.round = 1'b1;
      end
      round_shift_right_narrow_op: begin
        right      = 1'b1;
        ctl.round  = 1'b1;
        ctl.ow_sel = OW_HALF;
      end
      left_insert_op: ctl.ins = INS_LEFT;
      right_insert_op: begin
        right   = 1'b1;
        ctl.ins = INS_RIGHT;
      end
      right_accumulate_op: begin
        right          = 1'b1;
        ctl.accumulate = 1'b1;
      end
      round_right_accumulate_op: begin
        right          = 1'b1;
        ctl.accumulate = 1'b1;
        ctl.round      = 1'b1;
      end
      sat_shift_left_op: begin
        ctl.sat_kind = SAT_TYPED;
        ctl.use_reg  = shift_by_vector;
      end
      sat_round_shift_left_op: begin
        ctl.sat_kind = SAT_TYPED;
        ctl.use_reg  = 1'b1;
        ctl.round    = 1'b1;
      end
      sat_shift_right_narrow_op: begin
        right        = 1'b1;
        ctl.sat_kind = SAT_TYPED;
        ctl.ow_sel   = OW_HALF;
      end
      sat_round_right_narrow_op: begin
        right        = 1'b1;
        ctl.sat_kind = SAT_TYPED;
        ctl.ow_sel   = OW_HALF;
        ctl.round    = 1'b1;
      end
      usat_shift_left_op: ctl.sat_kind = SAT_UNS;
      usat_shift_right_narrow_op: begin
        right        = 1'b1;
        ctl.sat_kind = SAT_UNS;
        ctl.ow_sel   = OW_HALF;
      end
      usat_round_right_narrow_op: begin
        right        = 1'b1;
        ctl.sat_kind = SAT_UNS;
        ctl.ow_sel   = OW_HALF;
        ctl.round    = 1'b1;
      end
      default: shift_op = 1'b0;
    endcase
    cnt_imm = right ? -8'({1'b0, imm_shift}) : 8'({1'b0, imm_shift});
  end

  for (genvar e = 0; e < 4; e++) begin : g_es
    localparam int SW = 8 << e;
    localparam int NL = 128 / SW;
    wire [63:0]   o_half;
    wire [63:0]   o_same;
    wire [63:0]   o_dbl;
    wire [NL-1:0] s_lane;
    wire [127:0]  src_w = {src_b, src_a};
    for (genvar i = 0; i < NL; i++) begin : g_ln
      wire [2*SW-1:0]   ds;
      wire [2*SW-1:0]   dd;
      wire [2*SW-1:0]   dl;
      wire [2*SW-1:0]   rl;
      wire signed [7:0] c;
      wire              sl;
      if (i < 64 / SW) begin : g_s
        assign ds = (2*SW)'(src_d[i*SW +: SW]);
        assign c  = ctl.use_reg ? src_b[i*SW +: 8] : cnt_imm;
        assign o_same[i*SW +: SW] = rl[SW-1:0];
      end else begin : g_ns
        assign ds = '0;
        assign c  = cnt_imm;
      end
      if (i < 32 / SW) begin : g_d
        assign dd = src_d[i*2*SW +: 2*SW];
        assign o_dbl[i*2*SW +: 2*SW] = rl;
      end else begin : g_nd
        assign dd = '0;
      end
      assign dl = (ctl.ow_sel == OW_HALF) ?
                  (2*SW)'(src_d[i*SW/2 +: SW/2]) :
                  (ctl.ow_sel == OW_DBL) ? dd : ds;
      assign o_half[i*SW/2 +: SW/2] = rl[SW/2-1:0];
      assign s_lane[i] = sl & ((ctl.ow_sel == OW_HALF) ||
                         (ctl.ow_sel == OW_SAME && i < 64 / SW) ||
                         (i < 32 / SW));
      shift_lane #(.SW(SW)) u_lane (
        .src (src_w[i*SW +: SW]),
        .dst (dl),
        .cnt (c),
        .ctl (ctl),
        .res (rl),
        .sat (sl)
      );
    end
    if (e == 3) begin : g_nl
      assign o_dbl = '0;
    end
    assign shift_res[e] = (ctl.ow_sel == OW_HALF) ? o_half :
                          (ctl.ow_sel == OW_DBL) ? o_dbl : o_same;
    assign sat_es[e] = |s_lane;
  end

  always_comb begin
    logic [63:0] r;
    logic [64:0] fr;
    logic        ix;
    logic        sat;
    logic        bad;
    logic        fpw;
    r   = 64'h0;
    fr  = 65'h0;
    ix  = 1'b0;
    sat = 1'b0;
    bad = 1'b0;
    fpw = (elem_size == ES_WORD);
    st_d           = st_q;
    st_d.valid     = op_valid;
    st_d.underflow = 1'b0;
    if (shift_op) begin
      r   = shift_res[elem_size];
      sat = sat_es[elem_size];
      bad = (ctl.ow_sel == OW_HALF && elem_size == ES_BYTE) ||
            (ctl.ow_sel == OW_DBL && elem_size == ES_DWORD);
    end else begin
      unique case (op)
        register_copy_op: r = src_a;
        invert_move_op:   r = ~src_a;
        swap_op:          r = src_b;
        duplicate_op: begin
          unique case (elem_size)
            ES_BYTE:  r = {8{src_a[7:0]}};
            ES_HALF:  r = {4{src_a[15:0]}};
            ES_WORD:  r = {2{src_a[31:0]}};
            default:  r = src_a;
          endcase
        end
        absolute_value_op: begin
          r   = fpw ? (src_a & ~(DP_SIGN | SP_SIGN)) : (src_a & ~DP_SIGN);
          bad = elem_size < ES_WORD;
        end
        negate_op: begin
          r   = fpw ? (src_a ^ (DP_SIGN | SP_SIGN)) : (src_a ^ DP_SIGN);
          bad = elem_size < ES_WORD;
        end
        fp_max_op, fp_min_op, fp_half_op: begin
          bad = elem_size < ES_WORD;
          if (fpw) begin
            for (int l = 0; l < 2; l++) begin
              fr = fp_calc({32'h0, src_a[32*l +: 32]},
                           {32'h0, src_b[32*l +: 32]}, 1'b0,
                           op == fp_half_op, op == fp_max_op);
              r[32*l +: 32] = fr[31:0];
              ix = ix | fr[64];
            end
          end else begin
            fr = fp_calc(src_a, src_b, 1'b1,
                         op == fp_half_op, op == fp_max_op);
            r  = fr[63:0];
            ix = fr[64];
          end
        end
        poly_mul_op: begin
          bad = elem_size > ES_HALF;
          if (elem_size == ES_BYTE) begin
            for (int l = 0; l < 8; l++)
              r[8*l +: 8] = 8'(clmul({8'h0, src_a[8*l +: 8]},
                                     {8'h0, src_b[8*l +: 8]}));
          end else begin
            for (int l = 0; l < 4; l++)
              r[16*l +: 16] = clmul(src_a[16*l +: 16],
                                    src_b[16*l +: 16]);
          end
        end
        default: bad = 1'b1;
      endcase
    end
    if (op_valid) begin
      st_d.result    = bad ? RESULT_RST : r;
      st_d.inexact   = ix & !bad;
      st_d.saturated = sat & !bad;
      st_d.illegal   = bad;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{valid: 1'b0, result: RESULT_RST, inexact: 1'b0,
                underflow: 1'b0, saturated: 1'b0, illegal: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign res_valid    = st_q.valid;
  assign result       = st_q.result;
  assign fp_inexact   = st_q.inexact;
  assign fp_underflow = st_q.underflow;
  assign saturated    = st_q.saturated;
  assign op_illegal   = st_q.illegal;
endmodule // simd_shift_and_ftz_datapath

`default_nettype wire
